// ### core/sram_params.svh
// geometry and latency constants for the burst sram core
`ifndef SRAM_PARAMS_SVH
`define SRAM_PARAMS_SVH

// x36 organisation: 1M locations of two 36-bit words
`define ADDR_W       32'h0000_0014
`define WORD_W       32'h0000_0024

// read fifo toward the output clock domain
`define FIFO_DEPTH   32'h0000_0008
`define FIFO_AW      32'h0000_0003

// read latency in clock edges after address capture (one edge = half a cycle)
`define LAT_HI_EDGES 32'h0000_0003
`define LAT_LO_EDGES 32'h0000_0002

`endif

// ### core/sram_pkg.sv
// types shared by the burst sram core
`default_nettype none
package sram_pkg;
  `include "sram_params.svh"

  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`ADDR_W-1:0] addr_t;

  typedef struct packed {
    word_t first;
    word_t second;
  } word_pair_t;

  typedef struct packed {
    addr_t      addr;
    word_pair_t data;
  } wr_pend_t;

  typedef enum logic {
    SLOT_READ  = 1'b0,
    SLOT_WRITE = 1'b1
  } slot_t;

  typedef enum logic {
    W_IDLE   = 1'b0,
    W_SECOND = 1'b1
  } wr_state_t;

  typedef enum logic [1:0] {
    L_IDLE   = 2'b00,
    L_HOLD   = 2'b01,
    L_FIRST  = 2'b10,
    L_SECOND = 2'b11
  } lnk_state_t;
endpackage : sram_pkg
`default_nettype wire

// ### core/ddr_burst_sram.sv
// two-port double-data-rate burst sram core with read fifo toward the output clock
`timescale 1ns/100ps
`default_nettype none
`include "sram_params.svh"

module burst_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // filling side
  input  wire logic             in_clk,
  input  wire logic             in_rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  input  wire logic             out_clk,
  input  wire logic             out_rst_n,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW:0]      wbin;
  logic [AW:0]      wgray;
  logic [AW:0]      rbin;
  logic [AW:0]      rgray;
  logic [AW:0]      wg_s1;
  logic [AW:0]      wg_s2;
  logic [AW:0]      rg_s1;
  logic [AW:0]      rg_s2;
  logic [AW:0]      next_wbin;
  logic [AW:0]      next_rbin;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  assign next_wbin = wbin + 1'b1;
  assign next_rbin = rbin + 1'b1;
  // full when the write pointer is a whole lap ahead of the synced read pointer
  assign in_ready  = (wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
  assign out_valid = (rgray != wg_s2);
  assign out_data  = store[rbin[AW-1:0]];

  always_ff @(posedge in_clk) begin
    if (in_valid && in_ready) begin
      store[wbin[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge in_clk or negedge in_rst_n) begin
    if (!in_rst_n) begin
      wbin  <= '0;
      wgray <= '0;
    end else if (in_valid && in_ready) begin
      wbin  <= next_wbin;
      wgray <= to_gray(next_wbin);
    end
  end

  always_ff @(posedge in_clk or negedge in_rst_n) begin
    if (!in_rst_n) begin
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      rg_s1 <= rgray;
      rg_s2 <= rg_s1;
    end
  end

  always_ff @(posedge out_clk or negedge out_rst_n) begin
    if (!out_rst_n) begin
      rbin  <= '0;
      rgray <= '0;
    end else if (out_valid && out_ready) begin
      rbin  <= next_rbin;
      rgray <= to_gray(next_rbin);
    end
  end

  always_ff @(posedge out_clk or negedge out_rst_n) begin
    if (!out_rst_n) begin
      wg_s1 <= '0;
      wg_s2 <= '0;
    end else begin
      wg_s1 <= wgray;
      wg_s2 <= wg_s1;
    end
  end
endmodule : burst_fifo

module ddr_burst_sram (
  // clocks and reset; each clock edge stands for one rising edge of a clock pair member
  input  wire logic                 ref_clk,
  input  wire logic                 out_clk,
  input  wire logic                 nrst,
  // address and selects
  input  wire sram_pkg::addr_t      address,
  input  wire logic                 read_port_select_n,
  input  wire logic                 write_port_select_n,
  // write data
  input  wire sram_pkg::word_t      write_data,
  // static mode pins
  input  wire logic                 pll_bypass_pin,
  input  wire logic                 single_clock_mode,
  // read side
  output logic                      read_ready,
  output sram_pkg::word_t           read_data,
  output logic [1:0]                return_strobe_pair
);
  sram_pkg::word_pair_t  mem [0:(2**`ADDR_W)-1];

  sram_pkg::slot_t       slot;
  sram_pkg::wr_state_t   wr_state;
  sram_pkg::addr_t       wr_addr;
  sram_pkg::word_t       wr_first;
  logic                  pend_valid;
  sram_pkg::wr_pend_t    pend;
  sram_pkg::addr_t       rd_addr;
  logic [4:1]            rd_vld;
  sram_pkg::word_pair_t  fetch;
  sram_pkg::word_pair_t  rd_pair;
  sram_pkg::word_pair_t  rd_pair2;
  sram_pkg::word_t       ref_q;
  logic                  ref_echo;
  logic                  rd_take;
  logic                  w0_now;
  logic                  w1_now;
  logic                  byp_r1;
  logic                  byp_r2;
  logic                  sgl_r1;
  logic                  sgl_r2;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  sram_pkg::word_pair_t  fifo_out_data;
  logic                  lnk_rst1;
  logic                  lnk_rst_n;
  logic                  byp_l1;
  logic                  byp_l2;
  sram_pkg::lnk_state_t  lnk_state;
  sram_pkg::word_pair_t  lnk_pair;
  sram_pkg::word_t       lnk_q;
  logic                  lnk_echo;

  // mode pins are static but asynchronous to both clocks
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      byp_r1 <= 1'b0;
      byp_r2 <= 1'b0;
      sgl_r1 <= 1'b0;
      sgl_r2 <= 1'b0;
    end else begin
      byp_r1 <= pll_bypass_pin;
      byp_r2 <= byp_r1;
      sgl_r1 <= single_clock_mode;
      sgl_r2 <= sgl_r1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slot <= sram_pkg::SLOT_READ;
    end else begin
      slot <= (slot == sram_pkg::SLOT_READ) ? sram_pkg::SLOT_WRITE : sram_pkg::SLOT_READ;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_state <= sram_pkg::W_IDLE;
      wr_addr  <= '0;
      wr_first <= '0;
    end else begin
      case (wr_state)
        sram_pkg::W_IDLE: begin
          if (slot == sram_pkg::SLOT_WRITE && !write_port_select_n) begin
            wr_addr  <= address;
            wr_first <= write_data;
            wr_state <= sram_pkg::W_SECOND;
          end
        end
        sram_pkg::W_SECOND: begin
          wr_state <= sram_pkg::W_IDLE;
        end
        default: begin
          wr_state <= sram_pkg::W_IDLE;
        end
      endcase
    end
  end

  // second burst word joins the first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend_valid <= 1'b0;
      pend       <= '0;
    end else begin
      pend_valid <= (wr_state == sram_pkg::W_SECOND);
      if (wr_state == sram_pkg::W_SECOND) begin
        pend.addr        <= wr_addr;
        pend.data.first  <= wr_first;
        pend.data.second <= write_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (pend_valid) begin
      mem[pend.addr] <= pend.data;
    end
  end

  assign rd_take    = (slot == sram_pkg::SLOT_READ) && !read_port_select_n
                      && (sgl_r2 || fifo_in_ready);
  assign read_ready = sgl_r2 || fifo_in_ready;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_addr <= '0;
      rd_vld  <= '0;
    end else begin
      rd_vld <= {rd_vld[3:1], rd_take};
      if (rd_take) begin
        rd_addr <= address;
      end
    end
  end

  always_comb begin
    if (pend_valid && pend.addr == rd_addr) begin
      fetch = pend.data;
    end else begin
      fetch = mem[rd_addr];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_pair  <= '0;
      rd_pair2 <= '0;
    end else begin
      if (rd_vld[1]) begin
        rd_pair <= fetch;
      end
      // second copy keeps word two alive when reads follow back to back
      if (rd_vld[2]) begin
        rd_pair2 <= rd_pair;
      end
    end
  end

  assign w0_now = byp_r2 ? rd_vld[`LAT_HI_EDGES] : rd_vld[`LAT_LO_EDGES];
  assign w1_now = byp_r2 ? rd_vld[`LAT_HI_EDGES + 1] : rd_vld[`LAT_LO_EDGES + 1];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref_q    <= '0;
      ref_echo <= 1'b0;
    end else begin
      ref_echo <= ~ref_echo;
      if (w0_now) begin
        ref_q <= rd_pair.first;
      end else if (w1_now) begin
        ref_q <= rd_pair2.second;
      end
    end
  end

  burst_fifo #(
    .WIDTH ($bits(sram_pkg::word_pair_t)),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_read_fifo (
    .in_clk    (ref_clk),
    .in_rst_n  (nrst),
    .in_valid  (rd_vld[1] && !sgl_r2),
    .in_ready  (fifo_in_ready),
    .in_data   (fetch),
    .out_clk   (out_clk),
    .out_rst_n (lnk_rst_n),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // reset leaves the output domain only on its own clock
  always_ff @(posedge out_clk or negedge nrst) begin
    if (!nrst) begin
      lnk_rst1  <= 1'b0;
      lnk_rst_n <= 1'b0;
    end else begin
      lnk_rst1  <= 1'b1;
      lnk_rst_n <= lnk_rst1;
    end
  end

  always_ff @(posedge out_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      byp_l1 <= 1'b0;
      byp_l2 <= 1'b0;
    end else begin
      byp_l1 <= pll_bypass_pin;
      byp_l2 <= byp_l1;
    end
  end

  assign fifo_out_ready = (lnk_state == sram_pkg::L_IDLE);

  always_ff @(posedge out_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      lnk_state <= sram_pkg::L_IDLE;
      lnk_pair  <= '0;
      lnk_q     <= '0;
    end else begin
      case (lnk_state)
        sram_pkg::L_IDLE: begin
          if (fifo_out_valid) begin
            lnk_pair  <= fifo_out_data;
            // extra half cycle when bypass high
            lnk_state <= byp_l2 ? sram_pkg::L_HOLD : sram_pkg::L_FIRST;
          end
        end
        sram_pkg::L_HOLD: begin
          lnk_state <= sram_pkg::L_FIRST;
        end
        sram_pkg::L_FIRST: begin
          lnk_q     <= lnk_pair.first;
          lnk_state <= sram_pkg::L_SECOND;
        end
        sram_pkg::L_SECOND: begin
          lnk_q     <= lnk_pair.second;
          lnk_state <= sram_pkg::L_IDLE;
        end
        default: begin
          lnk_state <= sram_pkg::L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge out_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      lnk_echo <= 1'b0;
    end else begin
      lnk_echo <= ~lnk_echo;
    end
  end

  assign read_data          = sgl_r2 ? ref_q : lnk_q;
  assign return_strobe_pair = sgl_r2 ? {~ref_echo, ref_echo} : {~lnk_echo, lnk_echo};
endmodule : ddr_burst_sram
`default_nettype wire

// ### tb/ddr_burst_sram_properties.sv
// bound assertions on the burst sram core ports
`timescale 1ns/100ps
`default_nettype none
module ddr_burst_sram_properties (
  // clocks and reset
  input wire logic            ref_clk,
  input wire logic            out_clk,
  input wire logic            nrst,
  // requests and mode pins
  input wire sram_pkg::addr_t address,
  input wire logic            read_port_select_n,
  input wire logic            write_port_select_n,
  input wire sram_pkg::word_t write_data,
  input wire logic            pll_bypass_pin,
  input wire logic            single_clock_mode,
  // read side
  input wire logic            read_ready,
  input wire sram_pkg::word_t read_data,
  input wire logic [1:0]      return_strobe_pair
);
  logic [3:0] n;
  logic [3:0] m;
  logic       ws;
  wire logic  tk = !ws && !read_port_select_n && read_ready;
  // ws set: the coming edge is a write slot
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      n  <= 4'h0;
      ws <= 1'h0;
    end else begin
      ws <= !ws;
      if (n != 4'hf) n <= n + 4'h1;
    end
  end
  // out domain leaves reset late, so count its edges apart
  always_ff @(posedge out_clk or negedge nrst) begin
    if (!nrst) m <= 4'h0;
    else if (m != 4'hf) m <= m + 4'h1;
  end
  a_echo_pair: assert property (@(posedge ref_clk) disable iff (!nrst)
    return_strobe_pair[1] != return_strobe_pair[0]) else $error("echo strobes equal");
  a_echo_ref: assert property (@(posedge ref_clk) disable iff (!nrst)
    single_clock_mode && n > 4'h4 |-> return_strobe_pair != $past(return_strobe_pair))
    else $error("echo stalled on ref clock");
  a_echo_out: assert property (@(posedge out_clk) disable iff (!nrst)
    !single_clock_mode && m > 4'h5 |-> return_strobe_pair != $past(return_strobe_pair))
    else $error("echo stalled on out clock");
  // a word launched at edge t+2 is first seen by the sampled value at t+3
  a_coh_lo: assert property (@(posedge ref_clk) disable iff (!nrst)
    single_clock_mode && !pll_bypass_pin && n > 4'h3 && tk && !$past(write_port_select_n)
    && address == $past(address) |-> ##3 read_data == $past(write_data, 4)
    ##1 read_data == $past(write_data, 4)) else $error("short latency read wrong");
  a_coh_hi: assert property (@(posedge ref_clk) disable iff (!nrst)
    single_clock_mode && pll_bypass_pin && n > 4'h3 && tk && !$past(write_port_select_n)
    && address == $past(address) |-> ##4 read_data == $past(write_data, 5)
    ##1 read_data == $past(write_data, 5)) else $error("long latency read wrong");
  a_data_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    single_clock_mode && n > 4'h6 && $changed(read_data) |-> (pll_bypass_pin ?
    ($past(tk, 4) || $past(tk, 5)) : ($past(tk, 3) || $past(tk, 4))))
    else $error("read data moved without a read");
  a_ready_single: assert property (@(posedge ref_clk) disable iff (!nrst)
    single_clock_mode && n > 4'h3 |-> read_ready) else $error("single mode refused read");
  a_ready_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(read_ready) |-> $past(tk, 2)) else $error("ready fell without a read");
endmodule : ddr_burst_sram_properties
bind ddr_burst_sram ddr_burst_sram_properties i_props (.ref_clk, .out_clk, .nrst, .address,
  .read_port_select_n, .write_port_select_n, .write_data, .pll_bypass_pin,
  .single_clock_mode, .read_ready, .read_data, .return_strobe_pair);
`default_nettype wire

// ### tb/sram_ctrl_model.sv
// memory controller model placing requests in their address slots
`timescale 1ns/100ps
`default_nettype none
module sram_ctrl_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // request pins
  output sram_pkg::addr_t address,
  output logic            read_port_select_n,
  output logic            write_port_select_n,
  output sram_pkg::word_t write_data
);
  sram_pkg::addr_t    rq[$];
  sram_pkg::wr_pend_t wq[$];
  sram_pkg::word_t    sec;
  logic               ws;
  logic               wsec;
  initial begin
    {address, read_port_select_n, write_port_select_n, write_data} = '1;
  end
  function automatic int pending();
    return rq.size() + wq.size();
  endfunction : pending
  task automatic push_rd(input int a);
    rq.push_back(sram_pkg::addr_t'(a));
  endtask : push_rd
  task automatic push_wr(input int a, input sram_pkg::word_pair_t d);
    wq.push_back({sram_pkg::addr_t'(a), d});
  endtask : push_wr
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ws <= 1'h0;
      wsec <= 1'h0;
      read_port_select_n <= 1'h1;
      write_port_select_n <= 1'h1;
    end else begin
      ws <= !ws;
      wsec <= !ws && wq.size() > 0;
      read_port_select_n <= !(ws && rq.size() > 0);
      write_port_select_n <= !(!ws && wq.size() > 0);
      // lines not carrying a request show a changing pattern, never the last value
      if (!ws && wq.size() > 0) begin
        address <= wq[0].addr;
        write_data <= wq[0].data.first;
        sec <= wq[0].data.second;
        wq.delete(0);
      end else begin
        address <= (ws && rq.size() > 0) ? rq[0] : ~address;
        write_data <= wsec ? sec : ~write_data;
        if (ws && rq.size() > 0) rq.delete(0);
      end
    end
  end
endmodule : sram_ctrl_model
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the burst sram core
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t %h %h", $time, (a), (e)); end end
module testbench;
  typedef struct {int due; sram_pkg::word_t w;} exp_t;
  logic                 ref_clk = 1'h0;
  logic                 out_clk = 1'h0;
  logic                 run = 1'h1;
  logic                 nrst = 1'h0;
  logic                 pll_bypass_pin = 1'h0;
  logic                 single_clock_mode = 1'h1;
  logic                 read_port_select_n;
  logic                 write_port_select_n;
  logic                 read_ready;
  logic                 wp;
  logic [1:0]           return_strobe_pair;
  sram_pkg::addr_t      address;
  sram_pkg::addr_t      wa;
  sram_pkg::word_t      write_data;
  sram_pkg::word_t      read_data;
  sram_pkg::word_t      w0;
  sram_pkg::word_t      last;
  sram_pkg::word_pair_t mem[int];
  exp_t                 q[$];
  int                   fails;
  int                   checks_done;
  int                   n;
  sram_ctrl_model i_sram_ctrl_model (.ref_clk, .nrst, .address, .read_port_select_n,
    .write_port_select_n, .write_data);
  ddr_burst_sram i_ddr_burst_sram (.ref_clk, .out_clk, .nrst, .address, .read_port_select_n,
    .write_port_select_n, .write_data, .pll_bypass_pin, .single_clock_mode, .read_ready,
    .read_data, .return_strobe_pair);
  always #25 ref_clk = ~ref_clk;
  // link clock stands still while run is low, to stall the read fifo
  initial begin
    #7;
    forever #16 if (run) out_clk = ~out_clk;
  end
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      n = 0;
      wp = 1'h0;
      last = '0;
      q.delete();
    end else begin
      n++;
      if (wp) mem[wa] = {w0, write_data};
      wp = n[0] == 1'h0 && !write_port_select_n;
      wa = address;
      w0 = write_data;
      if (n[0] && !read_port_select_n && read_ready) begin
        q.push_back('{n + 2 + pll_bypass_pin, mem[address].first});
        q.push_back('{n + 3 + pll_bypass_pin, mem[address].second});
      end
    end
  end
  always @(negedge ref_clk)
    if (single_clock_mode && q.size() > 0 && q[0].due == n) begin
      `CHK(read_data, q[0].w)
      q.delete(0);
    end
  always @(negedge out_clk)
    if (!single_clock_mode && read_data !== last) begin
      last = read_data;
      `CHK(read_data, q.size() > 0 ? q[0].w : ~read_data)
      if (q.size() > 0) q.delete(0);
    end
  task automatic finish_test;
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic wait_idle;
    repeat (900) if (i_sram_ctrl_model.pending() > 0 || q.size() > 0) @(negedge ref_clk);
    if (i_sram_ctrl_model.pending() > 0 || q.size() > 0) begin
      fails++;
      finish_test;
    end
  endtask : wait_idle
  task automatic phase(input logic bp, input logic sm, input int cnt);
    @(posedge ref_clk);
    nrst <= 1'h0;
    pll_bypass_pin <= bp;
    single_clock_mode <= sm;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'h1;
    repeat (4) @(negedge ref_clk);
    for (int a = 0; a < 8; a++) i_sram_ctrl_model.push_wr(a, 72'({$urandom, $urandom, $urandom}));
    wait_idle;
    repeat (cnt) begin
      @(negedge ref_clk);
      if ($urandom % 2) i_sram_ctrl_model.push_wr($urandom % 8, 72'({$urandom, $urandom, $urandom}));
      if ($urandom % 2) i_sram_ctrl_model.push_rd($urandom % 8);
    end
    wait_idle;
  endtask : phase
  initial begin
    void'($urandom(32'hf253));
    phase(1'h0, 1'h1, 60);
    phase(1'h1, 1'h1, 60);
    phase(1'h0, 1'h0, 40);
    phase(1'h1, 1'h0, 40);
    run = 1'h0;
    repeat (12) i_sram_ctrl_model.push_rd($urandom % 8);
    repeat (100) if (i_sram_ctrl_model.pending() > 0) @(negedge ref_clk);
    `CHK(read_ready, 1'h0)
    run = 1'h1;
    wait_idle;
    `CHK(read_ready, 1'h1)
    finish_test;
  end
endmodule : testbench
`default_nettype wire
